// ===== design/bkr_buck_level_regs.sv
// bkr_buck_level_regs: four 24-bit buck level registers behind apb.
// assumes an apb4 master on core_clk; rst_b is the system reset.
//
// Contract
// - reg 24 bits 0-4: rw normal level of buck one, never reset
// - reg 24 bits 5-9: rw scaled level of buck one, never reset
// - reg 24 bits 10-14: rw standby level of buck one, never reset
// - reg 24 bits 15-18: rw slow-scale upper limit, reset to 1010
// - reg 24 bits 19-22: rw lower limit, top bit zero, reset 1000
// - reg 24 bit 23: rw range select of buck one, never reset
// - reg 25 repeats reg 24 layout and resets for buck two
// - reg 26: normal level bits 0-4, spare rw bits 5-9, no reset
// - reg 26: standby 10-14, range 23 rw unreset, 15-22 read zero
// - reg 27: normal 0-4, spare 5-9, standby 10-14, never reset
// - reg 27 bit 23 rw range unreset; bits 15-22 read zero
`timescale 1ns/1ps
`include "bkr_defines.svh"
module bkr_buck_level_regs #(
  parameter int ADDR_W = 8,
  parameter int NUM_BUCK = 4,
  parameter int NUM_LIMIT = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // level codes towards the regulators
  output bkr_pkg::bkr_levels_t [NUM_BUCK-1:0] levels
);

  // word indices of the four registers; byte address is four times these
  localparam logic [ADDR_W-3:0] IDX_ONE =
    (ADDR_W-2)'(`BKR_IDX_ONE);
  localparam logic [ADDR_W-3:0] IDX_TWO =
    (ADDR_W-2)'(`BKR_IDX_TWO);
  localparam logic [ADDR_W-3:0] IDX_THREE =
    (ADDR_W-2)'(`BKR_IDX_THREE);
  localparam logic [ADDR_W-3:0] IDX_FOUR =
    (ADDR_W-2)'(`BKR_IDX_FOUR);

  bkr_pkg::bkr_resp_t resp_q;
  logic [NUM_BUCK-1:0] hit;
  logic map_err;
  logic commit;
  logic [23:0] lane_mask;
  logic [23:0] wr_mask [NUM_BUCK];
  logic [23:0] rd_word [NUM_BUCK];
  logic [31:0] rd_data;
  logic [ADDR_W-3:0] word_idx;
  logic aligned;

  // the low two address bits must be zero: byte offsets hit nothing
  always_comb
  begin
    word_idx = paddr[ADDR_W-1:2];
    aligned = (paddr[1:0] == 2'b00);
  end

  // address decode; a misaligned or foreign address hits nothing
  always_comb
  begin
    hit = '0;
    map_err = 1'b0;
    if (aligned && word_idx == IDX_ONE)
    begin
      hit[0] = 1'b1;
    end
    else if (aligned && word_idx == IDX_TWO)
    begin
      hit[1] = 1'b1;
    end
    else if (aligned && word_idx == IDX_THREE)
    begin
      hit[2] = 1'b1;
    end
    else if (aligned && word_idx == IDX_FOUR)
    begin
      hit[3] = 1'b1;
    end
    else
    begin
      map_err = 1'b1;
    end
  end

  // a write lands only at the edge where the master sees pready
  always_comb
  begin
    commit = psel & penable & pwrite & resp_q.pready & ~resp_q.pslverr;
  end

  // byte lanes 0 to 2 cover the 24 bits; lane 3 has nothing behind it
  always_comb
  begin
    lane_mask = {{8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  end

  // write data split by field; the same slices feed every register
  logic [4:0] wd_normal;
  logic [4:0] wd_scaled;
  logic [4:0] wd_standby;
  logic [3:0] wd_upper;
  logic [3:0] wd_lower;
  logic wd_range;

  always_comb
  begin
    wd_normal = pwdata[`BKR_NORMAL_MSB:`BKR_NORMAL_LSB];
    wd_scaled = pwdata[`BKR_SCALED_MSB:`BKR_SCALED_LSB];
    wd_standby = pwdata[`BKR_STANDBY_MSB:`BKR_STANDBY_LSB];
    wd_upper = pwdata[`BKR_UPPER_MSB:`BKR_UPPER_LSB];
    wd_lower = pwdata[`BKR_LOWER_MSB:`BKR_LOWER_LSB];
    wd_range = pwdata[`BKR_RANGE_BIT];
  end

  // pprot, lane 3 and bits 31 to 24 carry no meaning here; every
  // access level may write, and the top byte has no storage behind it
  logic spare_inputs;
  always_comb
  begin
    spare_inputs = ^pprot ^ pstrb[3] ^ (^pwdata[31:24]);
  end

  genvar g;
  generate
    for (g = 0; g < NUM_BUCK; g++)
    begin : g_buck
      logic [4:0] normal_q;
      logic [4:0] scaled_q;
      logic [4:0] standby_q;
      logic [0:0] range_q;
      logic [3:0] upper_q;
      logic [3:0] lower_q;
      logic [23:0] writable;
      logic wr_hit;
      logic [4:0] we_normal;
      logic [4:0] we_scaled;
      logic [4:0] we_standby;
      logic [0:0] we_range;

      always_comb
      begin
        wr_hit = commit & hit[g];
      end

      // only the first buckets own the slow-scaling window
      always_comb
      begin
        if (g < NUM_LIMIT)
          writable = `BKR_WR_MASK_FULL;
        else
          writable = `BKR_WR_MASK_LITE;
        wr_mask[g] = wr_hit ? (lane_mask & writable) : '0;
      end

      // per-field enables; a cleared strobe lane leaves its bits alone
      always_comb
      begin
        we_normal = wr_mask[g][`BKR_NORMAL_MSB:`BKR_NORMAL_LSB];
        we_scaled = wr_mask[g][`BKR_SCALED_MSB:`BKR_SCALED_LSB];
        we_standby = wr_mask[g][`BKR_STANDBY_MSB:`BKR_STANDBY_LSB];
        we_range = wr_mask[g][`BKR_RANGE_BIT];
      end

      bkr_field_reg #(
        .WIDTH(5),
        .HAS_RST(1'b0),
        .RST_VAL(5'h00)
      ) u_normal (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .wr_mask(we_normal),
        .wr_data(wd_normal),
        .q(normal_q)
      );

      // on buckets three and four this is spare storage, still driven onto scaled_level
      bkr_field_reg #(
        .WIDTH(5),
        .HAS_RST(1'b0),
        .RST_VAL(5'h00)
      ) u_scaled (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .wr_mask(we_scaled),
        .wr_data(wd_scaled),
        .q(scaled_q)
      );

      bkr_field_reg #(
        .WIDTH(5),
        .HAS_RST(1'b0),
        .RST_VAL(5'h00)
      ) u_standby (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .wr_mask(we_standby),
        .wr_data(wd_standby),
        .q(standby_q)
      );

      bkr_field_reg #(
        .WIDTH(1),
        .HAS_RST(1'b0),
        .RST_VAL(1'b0)
      ) u_range (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .wr_mask(we_range),
        .wr_data(wd_range),
        .q(range_q)
      );

      if (g < NUM_LIMIT)
      begin : g_limit
        bkr_field_reg #(
          .WIDTH(4),
          .HAS_RST(1'b1),
          .RST_VAL(`BKR_UPPER_RST)
        ) u_upper (
          .core_clk(core_clk),
          .rst_b(rst_b),
          .wr_mask(wr_mask[g][`BKR_UPPER_MSB:`BKR_UPPER_LSB]),
          .wr_data(wd_upper),
          .q(upper_q)
        );

        bkr_field_reg #(
          .WIDTH(4),
          .HAS_RST(1'b1),
          .RST_VAL(`BKR_LOWER_RST)
        ) u_lower (
          .core_clk(core_clk),
          .rst_b(rst_b),
          .wr_mask(wr_mask[g][`BKR_LOWER_MSB:`BKR_LOWER_LSB]),
          .wr_data(wd_lower),
          .q(lower_q)
        );
      end
      else
      begin : g_no_limit
        // read-only zeros; no flip-flop exists behind these bits
        always_comb
        begin
          upper_q = 4'h0;
          lower_q = 4'h0;
        end
      end

      // read word of this register
      always_comb
      begin
        rd_word[g] = '0;
        rd_word[g][`BKR_NORMAL_MSB:`BKR_NORMAL_LSB] = normal_q;
        rd_word[g][`BKR_SCALED_MSB:`BKR_SCALED_LSB] = scaled_q;
        rd_word[g][`BKR_STANDBY_MSB:`BKR_STANDBY_LSB] = standby_q;
        rd_word[g][`BKR_UPPER_MSB:`BKR_UPPER_LSB] = upper_q;
        rd_word[g][`BKR_LOWER_MSB:`BKR_LOWER_LSB] = lower_q;
        rd_word[g][`BKR_RANGE_BIT] = range_q[0];
      end

      // the lower limit is a five-bit level with its top bit zero
      always_comb
      begin
        levels[g].normal_level = normal_q;
        levels[g].scaled_level = scaled_q;
        levels[g].standby_level = standby_q;
        levels[g].slow_scale_upper = upper_q;
        levels[g].slow_scale_lower = {1'b0, lower_q};
        levels[g].range_select = range_q[0];
      end
    end
  endgenerate

  // read multiplexer; bits 31 to 24 always read zero
  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (hit[0])
    begin
      rd_data = {8'h00, rd_word[0]};
    end
    else if (hit[1])
    begin
      rd_data = {8'h00, rd_word[1]};
    end
    else if (hit[2])
    begin
      rd_data = {8'h00, rd_word[2]};
    end
    else if (hit[3])
    begin
      rd_data = {8'h00, rd_word[3]};
    end
  end

  bkr_apb_resp u_resp (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .map_err(map_err),
    .rd_data(rd_data),
    .resp_q(resp_q)
  );

  // answer comes straight from the response flip-flops
  always_comb
  begin
    pready = resp_q.pready;
    pslverr = resp_q.pslverr;
    prdata = resp_q.prdata;
  end

endmodule

// ===== design/bkr_defines.svh
// bkr_defines.svh: offsets, field positions and reset values of the
// buck level register bank; assumes a 32-bit apb with byte addressing.
`ifndef BKR_DEFINES_SVH
`define BKR_DEFINES_SVH

// register indices as numbered; byte address is four times the index
`define BKR_IDX_ONE 6'd24
`define BKR_IDX_TWO 6'd25
`define BKR_IDX_THREE 6'd26
`define BKR_IDX_FOUR 6'd27

// field positions inside each 24-bit register
`define BKR_NORMAL_LSB 0
`define BKR_NORMAL_MSB 4
`define BKR_SCALED_LSB 5
`define BKR_SCALED_MSB 9
`define BKR_STANDBY_LSB 10
`define BKR_STANDBY_MSB 14
`define BKR_UPPER_LSB 15
`define BKR_UPPER_MSB 18
`define BKR_LOWER_LSB 19
`define BKR_LOWER_MSB 22
`define BKR_RANGE_BIT 23

// system reset values of the slow-scaling window
`define BKR_UPPER_RST 4'ha
`define BKR_LOWER_RST 4'h8

// bits that software may change
`define BKR_WR_MASK_FULL 24'hffffff
`define BKR_WR_MASK_LITE 24'h807fff

`endif

// ===== design/bkr_pkg.sv
// bkr_pkg: types shared by the buck level register bank.
// widths are written out here and must match bkr_defines.svh.
package bkr_pkg;

  typedef struct packed {
    logic range_select;
    logic [4:0] slow_scale_lower;
    logic [3:0] slow_scale_upper;
    logic [4:0] standby_level;
    logic [4:0] scaled_level;
    logic [4:0] normal_level;
  } bkr_levels_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } bkr_resp_t;

endpackage

// ===== design/bkr_field_reg.sv
// bkr_field_reg: one register field with a per-bit write mask.
// assumes masks come from a completed apb write; an unreset field
// powers up unknown and keeps its value through every reset.
`timescale 1ns/1ps
module bkr_field_reg #(
  parameter int WIDTH = 5,
  parameter bit HAS_RST = 1'b0,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // write side
  input wire logic [WIDTH-1:0] wr_mask,
  input wire logic [WIDTH-1:0] wr_data,
  // stored value
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] field_d;

  always_comb
  begin
    field_d = (q & ~wr_mask) | (wr_data & wr_mask);
  end

  generate
    if (HAS_RST)
    begin : g_rst
      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
          q <= RST_VAL;
        else
          q <= field_d;
      end
    end
    else
    begin : g_keep
      // no reset on purpose: the level codes survive every reset
      always_ff @(posedge core_clk)
      begin
        q <= field_d;
      end
    end
  endgenerate

endmodule

// ===== design/bkr_apb_resp.sv
// bkr_apb_resp: registered apb answer, one wait state per transfer.
// assumes psel, penable and pwrite are synchronous to core_clk.
`timescale 1ns/1ps
module bkr_apb_resp (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic map_err,
  input wire logic [31:0] rd_data,
  // answer
  output bkr_pkg::bkr_resp_t resp_q
);

  bkr_pkg::bkr_resp_t resp_d;

  always_comb
  begin
    resp_d = resp_q;
    resp_d.pready = psel & penable & ~resp_q.pready;
    if (psel && penable && !resp_q.pready)
    begin
      resp_d.pslverr = map_err;
      resp_d.prdata = pwrite ? 32'h0000_0000 : rd_data;
    end
    else
    begin
      resp_d.pslverr = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      resp_q <= '0;
    else
      resp_q <= resp_d;
  end

endmodule

// ===== sim/bkr_buck_level_regs_chk.sv
// bkr_buck_level_regs_chk: port assertions for the buck level bank.
// assumes one clock domain; bound onto bkr_buck_level_regs below.
`timescale 1ns/1ps
module bkr_buck_level_regs_chk #(
  parameter int ADDR_W = 8,
  parameter int NUM_BUCK = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // level codes
  input wire bkr_pkg::bkr_levels_t [NUM_BUCK-1:0] levels
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_done;
    psel && penable && pready && pwrite && !pslverr;
  endsequence
  a_one_wait: assert property (s_wait |=> pready)
    else $error("answer late");
  a_err_unmapped: assert property (
    pready |-> pslverr == !(paddr inside {8'h60, 8'h64, 8'h68, 8'h6c}))
    else $error("error flag wrong");
  a_upper_reset: assert property ($rose(rst_b) |->
    levels[0].slow_scale_upper == 4'ha && levels[1].slow_scale_upper == 4'ha)
    else $error("upper limit reset wrong");
  a_lower_reset: assert property ($rose(rst_b) |->
    levels[0].slow_scale_lower == 5'h08 && levels[1].slow_scale_lower == 5'h08)
    else $error("lower limit reset wrong");
  a_lower_top: assert property (
    levels[0].slow_scale_lower[4] == 1'b0 &&
    levels[1].slow_scale_lower[4] == 1'b0)
    else $error("lower limit top bit set");
  a_lite_zero: assert property ({levels[2].slow_scale_upper,
    levels[2].slow_scale_lower, levels[3].slow_scale_upper,
    levels[3].slow_scale_lower} == 18'h0)
    else $error("unused limits not zero");
  a_normal_wr: assert property (
    s_done ##0 (paddr == 8'h60 && pstrb[0])
    |=> levels[0].normal_level == $past(pwdata[4:0]))
    else $error("normal level not written");
  a_range_wr: assert property (
    s_done ##0 (paddr == 8'h6c && pstrb[2])
    |=> levels[3].range_select == $past(pwdata[23]))
    else $error("range bit not written");
  a_read_zero: assert property (
    pready && !pwrite && !pslverr |->
    prdata[31:24] == 8'h0 && (paddr < 8'h68 || prdata[22:15] == 8'h0))
    else $error("read-only bits not zero");
  a_only_wr: assert property (
    $changed(levels) |-> $past(psel && penable && pready && pwrite))
    else $error("levels changed without a write");
endmodule

bind bkr_buck_level_regs bkr_buck_level_regs_chk #(
  .ADDR_W(ADDR_W),
  .NUM_BUCK(NUM_BUCK)
) u_chk (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .pready, .pslverr, .prdata, .levels);

// ===== sim/bkr_buck_level_regs_bench.sv
// bkr_buck_level_regs_bench: self-checking bench for the buck level bank.
// assumes the design files and the checker are compiled before it.
`timescale 1ns/1ps
module bkr_buck_level_regs_bench;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] strb;
    logic [31:0] rdata;
    logic err;
  } bkr_row_t;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  bkr_pkg::bkr_levels_t [3:0] levels;
  logic [31:0] r;
  logic e;
  int failures = 0;
  int total_checks = 0;
  // unmapped rows sit on both sides of the bank
  bkr_row_t rows [7] = '{
    '{8'h60, 32'hffffffff, 4'hf, 32'h00ffffff, 1'b0},
    '{8'h64, 32'h12345678, 4'hf, 32'h00345678, 1'b0},
    '{8'h68, 32'hffffffff, 4'hf, 32'h00807fff, 1'b0},
    '{8'h6c, 32'h00aaaaaa, 4'hf, 32'h00802aaa, 1'b0},
    '{8'h60, 32'h00000000, 4'h1, 32'h00ffff00, 1'b0},
    '{8'h70, 32'hffffffff, 4'hf, 32'h00000000, 1'b1},
    '{8'h5c, 32'hffffffff, 4'hf, 32'h00000000, 1'b1}};

  always #10 core_clk = ~core_clk;

  bkr_buck_level_regs DUT (.core_clk, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .pprot(3'h0), .pready, .pslverr, .prdata,
    .levels);

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one idle cycle before each setup keeps drivers single per step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] rd, output logic er);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      failures++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task give_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #20000;
    failures++;
    give_verdict;
  end

  initial
  begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    apb(1'b0, 8'h60, 32'h0, 4'h0, r, e);
    chk(r & 32'h007f8000, 32'h00450000);
    $display("reset values done");
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].addr, rows[i].wdata, rows[i].strb, r, e);
      chk({31'h0, e}, {31'h0, rows[i].err});
      apb(1'b0, rows[i].addr, 32'h0, 4'h0, r, e);
      chk(r, rows[i].rdata);
    end
    chk({27'h0, levels[1].normal_level}, 32'h18);
    chk({27'h0, levels[0].slow_scale_lower}, 32'h0f);
    chk({27'h0, levels[3].standby_level}, 32'h0a);
    $display("rows done");
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    apb(1'b0, 8'h60, 32'h0, 4'h0, r, e);
    chk(r, 32'h00c57f00);
    apb(1'b0, 8'h64, 32'h0, 4'h0, r, e);
    chk(r, 32'h00455678);
    apb(1'b0, 8'h6c, 32'h0, 4'h0, r, e);
    chk(r, 32'h00802aaa);
    $display("second reset done");
    give_verdict;
  end
endmodule
